// >>> rtl/rxagc_top.sv
// The APB interface to the registers and the register offsets were chosen for this implementation.
`timescale 1ns/1ps
module rxagc_top import rxagc_pkg::*; (
  input  logic              mclk,                  // Encode clock
  input  logic              rst,                   // Async reset
  input  logic              psel,                  // APB select
  input  logic              penable,               // APB enable
  input  logic              pwrite,                // APB direction
  input  logic [7:0]        paddr,                 // APB byte address
  input  logic [31:0]       pwdata,                // APB write data
  output logic [31:0]       prdata,                // APB read data
  output logic              pready,                // APB ready
  output logic              pslverr,               // APB error
  input  logic              adc_valid,             // Converter sample strobe
  input  logic [11:0]       adc_i,                 // Converter I
  input  logic [11:0]       adc_q,                 // Converter Q
  input  logic              nb_valid,              // Decimated sample strobe
  input  logic [15:0]       nb_i,                  // Filtered I
  input  logic [15:0]       nb_q,                  // Filtered Q
  input  logic              overdrive,             // Analog overdrive comparator
  output logic [GAIN_W-1:0] stepped_front_gain,    // Front gain code
  output logic              quick_gain_cut_loop,   // Cut loop active
  output logic              fade_recovery_loop     // Recovery loop engaged
);

  // ----------------------------------------
  // Registers and fields
  // ----------------------------------------
  logic [31:0] ctrl_reg;
  logic [31:0] slow_reg;
  logic [31:0] attack_reg;
  logic [31:0] floor_reg;
  logic [31:0] decay_reg;
  logic        enable;
  logic [7:0]  target_level_setting;
  logic [3:0]  slow_loop_gain_factor;
  logic [7:0]  slow_peak_period;
  logic [3:0]  hysteresis_setting;
  logic [3:0]  integ_setting;
  logic [4:0]  attack_step_setting;
  logic [4:0]  attack_count_setting;
  logic [9:0]  wideband_floor_setting;
  logic [9:0]  narrowband_floor_setting;
  logic [4:0]  decay_step_setting;
  logic [7:0]  decay_peak_period;

  assign enable                   = ctrl_reg[CTRL_EN_BIT];
  assign target_level_setting     = slow_reg[TGT_LSB +: 8];
  assign slow_loop_gain_factor    = slow_reg[SHIFT_LSB +: 4];
  assign slow_peak_period         = slow_reg[SPER_LSB +: 8];
  assign hysteresis_setting       = slow_reg[HYST_LSB +: 4];
  assign integ_setting            = slow_reg[INTEG_LSB +: 4];
  assign attack_step_setting      = attack_reg[ASTEP_LSB +: 5];
  assign attack_count_setting     = attack_reg[ACNT_LSB +: 5];
  assign wideband_floor_setting   = floor_reg[WBF_LSB +: 10];
  assign narrowband_floor_setting = floor_reg[NBF_LSB +: 10];
  assign decay_step_setting       = decay_reg[DSTEP_LSB +: 5];
  assign decay_peak_period        = decay_reg[DPER_LSB +: 8];

  // ----------------------------------------
  // APB slave
  // ----------------------------------------
  // Zero wait states: the access phase always completes in one cycle
  logic        apb_setup;
  logic        apb_write;
  logic        mapped;
  logic [31:0] status_word;
  logic [ACC_W-1:0] acc_reg;
  logic [9:0]  slow_latest_reg;
  logic        cut_busy;
  logic        fade_reg;

  assign apb_setup = psel & ~penable;
  assign apb_write = psel & penable & pready & pwrite;
  assign mapped    = (paddr == OFF_CTRL) || (paddr == OFF_SLOW) || (paddr == OFF_ATTACK) ||
                     (paddr == OFF_FLOOR) || (paddr == OFF_DECAY) || (paddr == OFF_STATUS);
  assign status_word = {10'h000, slow_latest_reg, 1'b0, fade_reg, cut_busy,
                        acc_reg[ACC_W-1 -: GAIN_W]};

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready  <= apb_setup;
      pslverr <= apb_setup & ~mapped;
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      prdata <= 32'h0000_0000;
    end else if (apb_setup && !pwrite) begin
      case (paddr)
        OFF_CTRL:   prdata <= ctrl_reg;
        OFF_SLOW:   prdata <= slow_reg;
        OFF_ATTACK: prdata <= attack_reg;
        OFF_FLOOR:  prdata <= floor_reg;
        OFF_DECAY:  prdata <= decay_reg;
        OFF_STATUS: prdata <= status_word;
        default:    prdata <= 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      ctrl_reg   <= CTRL_RST;
      slow_reg   <= SLOW_RST;
      attack_reg <= ATTACK_RST;
      floor_reg  <= FLOOR_RST;
      decay_reg  <= DECAY_RST;
    end else if (apb_write) begin
      case (paddr)
        OFF_CTRL:   ctrl_reg   <= pwdata;
        OFF_SLOW:   slow_reg   <= pwdata;
        OFF_ATTACK: attack_reg <= pwdata;
        OFF_FLOOR:  floor_reg  <= pwdata;
        OFF_DECAY:  decay_reg  <= pwdata;
        default:    ctrl_reg   <= ctrl_reg;
      endcase
    end
  end

  // ----------------------------------------
  // Peak detectors
  // ----------------------------------------
  logic       slow_done;
  logic [9:0] slow_atten;
  logic       wb_done;
  logic [9:0] wb_atten;
  logic       nb_done;
  logic [9:0] nb_atten;
  logic [9:0] wb_latest_reg;
  logic [9:0] wb_eff;

  rxagc_peak u_slow_peak (
    .mclk   (mclk),
    .rst    (rst),
    .valid  (adc_valid),
    .in_i   ({adc_i, 4'h0}),
    .in_q   ({adc_q, 4'h0}),
    .period (slow_peak_period),
    .done   (slow_done),
    .atten  (slow_atten)
  );

  // Wideband sees the raw converter output, blockers included
  rxagc_peak u_wide_peak (
    .mclk   (mclk),
    .rst    (rst),
    .valid  (adc_valid),
    .in_i   ({adc_i, 4'h0}),
    .in_q   ({adc_q, 4'h0}),
    .period (decay_peak_period),
    .done   (wb_done),
    .atten  (wb_atten)
  );

  rxagc_peak u_narrow_peak (
    .mclk   (mclk),
    .rst    (rst),
    .valid  (nb_valid),
    .in_i   (nb_i),
    .in_q   (nb_q),
    .period (decay_peak_period),
    .done   (nb_done),
    .atten  (nb_atten)
  );

  assign wb_eff = wb_done ? wb_atten : wb_latest_reg;

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      wb_latest_reg   <= ATTEN_ZERO;
      slow_latest_reg <= ATTEN_ZERO;
    end else begin
      if (wb_done) begin
        wb_latest_reg <= wb_atten;
      end
      if (slow_done) begin
        slow_latest_reg <= slow_atten;
      end
    end
  end

  // ----------------------------------------
  // Quick gain cut loop
  // ----------------------------------------
  logic       overdrive_q;
  logic       cut_start;
  logic [4:0] cut_count_eff;
  logic [4:0] cut_load;

  assign cut_start     = enable & overdrive & ~overdrive_q;
  assign cut_count_eff = (attack_count_setting == 5'h00) ? 5'h01 :
                         (attack_count_setting > 5'h10) ? 5'h10 : attack_count_setting;
  assign cut_load      = 5'(cut_count_eff + 5'h01);

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      overdrive_q <= 1'b0;
    end else begin
      overdrive_q <= overdrive;
    end
  end

  rxagc_cut_timer u_cut_timer (
    .mclk  (mclk),
    .rst   (rst),
    .start (cut_start),
    .load  (cut_load),
    .busy  (cut_busy)
  );

  // ----------------------------------------
  // Fade recovery loop
  // ----------------------------------------
  // Decision refreshed once per narrowband peak; wideband uses its latest result
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      fade_reg <= 1'b0;
    end else if (nb_done) begin
      fade_reg <= enable && (wb_eff > wideband_floor_setting) &&
                  (nb_atten > narrowband_floor_setting);
    end
  end

  // ----------------------------------------
  // Slow loop
  // ----------------------------------------
  logic [3:0]             integ_cnt_reg;
  logic [3:0]             integ_eff;
  logic [3:0]             shift_eff;
  logic                   slow_apply;
  logic signed [10:0]     slow_err;
  logic [10:0]            err_mag;
  logic                   err_big;
  logic signed [ACC_W+1:0] slow_delta;

  assign integ_eff  = (integ_setting == 4'h0) ? 4'h1 : integ_setting;
  // A factor of one or more would make the loop ring, so shift never drops to zero
  assign shift_eff  = (slow_loop_gain_factor == 4'h0) ? 4'h1 : slow_loop_gain_factor;
  assign slow_apply = slow_done && (integ_cnt_reg >= 4'(integ_eff - 4'h1));
  assign slow_err   = $signed({1'b0, slow_atten}) - $signed({3'b000, target_level_setting});
  assign err_mag    = slow_err[10] ? 11'(-slow_err) : slow_err;
  assign err_big    = err_mag > {7'h00, hysteresis_setting};
  assign slow_delta = ($signed((ACC_W+2)'(slow_err)) <<< FRAC_W) >>> shift_eff;

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      integ_cnt_reg <= 4'h0;
    end else if (slow_done) begin
      integ_cnt_reg <= slow_apply ? 4'h0 : 4'(integ_cnt_reg + 4'h1);
    end
  end

  // ----------------------------------------
  // Gain arbitration and accumulator
  // ----------------------------------------
  rxagc_mode_t             mode;
  logic [ACC_W-1:0]        acc_next;
  logic signed [ACC_W+1:0] acc_wide;
  logic signed [ACC_W+1:0] cut_amt;
  logic signed [ACC_W+1:0] raise_amt;

  assign acc_wide  = $signed({2'b00, acc_reg});
  assign cut_amt   = $signed((ACC_W+2)'({attack_step_setting, 16'h0000}));
  assign raise_amt = $signed((ACC_W+2)'({decay_step_setting, 16'h0000}));

  always_comb begin
    if (!enable) begin
      mode = MODE_HOLD;
    end else if (cut_busy) begin
      mode = MODE_ATTACK;
    end else if (fade_reg) begin
      mode = nb_done ? MODE_DECAY : MODE_HOLD;
    end else if (slow_apply && err_big) begin
      mode = MODE_SLOW;
    end else begin
      mode = MODE_HOLD;
    end
  end

  always_comb begin
    case (mode)
      MODE_ATTACK: acc_next = rxagc_sat(acc_wide - cut_amt);
      MODE_DECAY:  acc_next = rxagc_sat(acc_wide + raise_amt);
      MODE_SLOW:   acc_next = rxagc_sat(acc_wide + slow_delta);
      default:     acc_next = acc_reg;
    endcase
  end

  // Only the quick cut counts encode clock cycles; slow and fade steps follow peaks timed in sample strobes
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      acc_reg <= {GAIN_INIT, 16'h0000};
    end else begin
      acc_reg <= acc_next;
    end
  end

  assign stepped_front_gain  = acc_reg[ACC_W-1 -: GAIN_W];
  assign quick_gain_cut_loop = cut_busy;
  assign fade_recovery_loop  = fade_reg;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);

  sequence apb_setup_s;
    psel && !penable;
  endsequence

  sequence cut_step_s;
    enable && cut_busy && acc_wide >= cut_amt;
  endsequence

  apb_answer_a: assert property (apb_setup_s |=> pready && !$past(pready))
    else $error("apb access not answered in one cycle");
  cut_start_a: assert property (cut_start |=> quick_gain_cut_loop)
    else $error("overdrive did not start gain cut");
  cut_step_a: assert property (
    cut_step_s |=> acc_wide == $past(acc_wide) - $past(cut_amt))
    else $error("gain cut step wrong");
  cut_prio_a: assert property (
    enable && cut_busy && fade_reg |=> acc_reg <= $past(acc_reg))
    else $error("gain rose during cut");
  fade_engage_a: assert property (
    nb_done |=> fade_reg == $past(enable && (wb_eff > wideband_floor_setting) &&
                                  (nb_atten > narrowband_floor_setting)))
    else $error("fade engage decision wrong");
  fade_raise_a: assert property (
    enable && !cut_busy && fade_reg && nb_done && decay_step_setting != 5'h00 &&
    !(&acc_reg[ACC_W-1 -: GAIN_W]) |=> acc_reg > $past(acc_reg))
    else $error("fade recovery did not raise gain");
  slow_block_a: assert property (
    fade_reg && !nb_done && !cut_busy |=> acc_reg == $past(acc_reg))
    else $error("slow loop acted while fade engaged");
  slow_dir_a: assert property (
    mode == MODE_SLOW && !slow_err[10] |=> acc_reg >= $past(acc_reg))
    else $error("slow loop moved gain the wrong way");
  // A factor below one never moves the gain by more than half the error
  gain_shift_a: assert property (
    mode == MODE_SLOW && !slow_err[10] |=>
      acc_wide - $past(acc_wide) <= $signed({1'b0, $past(err_mag), 15'h0000}))
    else $error("loop gain factor reached one");
  reset_target_a: assert property (
    $past(rst) |-> target_level_setting == 8'h40 && wideband_floor_setting == 10'h1A9)
    else $error("levels not at reset defaults");

endmodule

// >>> pkg/rxagc_pkg.sv
// Function
// - Slow loop steers gain so peak input level tracks target, 0 to -24 dBFS.
// - Slow loop target level resets to -6.02 dBFS.
// - Slow loop correction scaled by gain factor, default 1/256, always below one.
// - Slow peak is dB of max(|I|,|Q|) over a programmed sample count.
// - Overdrive comparator trip lets quick cut loop override slow loop, lowering gain.
// - Each quick cut step is programmable 0 to 2.914 dB in 0.094 dB units; the 5-bit step field is not clamped and takes up to 31 units.
// - Quick cut lowers gain for count plus one cycles, count 1 to 16.
// - Fade recovery engages only while wideband and narrowband peaks are both below floors.
// - Wideband peak taken at converter output, narrowband after decimation filtering.
// - Wideband floor defaults -40 dBFS, narrowband floor -60 dBFS, both programmable.
// - Engaged fade recovery overrides slow loop and raises gain by programmed step.
// - Fade recovery peaks are measured over a programmed period, default 4 samples.
// - Slow: level, gain, hysteresis, integration; lower: level, step, rate; upper: step.
// - All loop timing counts cycles of the encode clock; only the quick cut does here, peak periods count sample strobes.
package rxagc_pkg;

  // ----------------------------------------
  // Widths and level scale
  // ----------------------------------------
  // Level unit is 6.02/64 dB, about 0.094 dB
  localparam int GAIN_W = 9;
  localparam int FRAC_W = 16;
  localparam int ACC_W  = GAIN_W + FRAC_W;
  localparam logic [GAIN_W-1:0] GAIN_INIT  = 9'h100;
  localparam logic [9:0]        ATTEN_ZERO = 10'h3FF;
  // Log code of a full-scale magnitude (2^15); loss counts down from here
  localparam logic [9:0]        LOG_FULL   = 10'h3C0;

  // ----------------------------------------
  // Register map
  // ----------------------------------------
  localparam logic [7:0] OFF_CTRL   = 8'h00;
  localparam logic [7:0] OFF_SLOW   = 8'h04;
  localparam logic [7:0] OFF_ATTACK = 8'h08;
  localparam logic [7:0] OFF_FLOOR  = 8'h0C;
  localparam logic [7:0] OFF_DECAY  = 8'h10;
  localparam logic [7:0] OFF_STATUS = 8'h14;

  localparam logic [31:0] CTRL_RST   = 32'h0000_0001;
  localparam logic [31:0] SLOW_RST   = 32'h1218_0840;
  localparam logic [31:0] ATTACK_RST = 32'h0000_0408;
  localparam logic [31:0] FLOOR_RST  = 32'h027E_01A9;
  localparam logic [31:0] DECAY_RST  = 32'h0000_0401;

  localparam int CTRL_EN_BIT = 0;
  localparam int TGT_LSB     = 0;
  localparam int SHIFT_LSB   = 8;
  localparam int SPER_LSB    = 16;
  localparam int HYST_LSB    = 24;
  localparam int INTEG_LSB   = 28;
  localparam int ASTEP_LSB   = 0;
  localparam int ACNT_LSB    = 8;
  localparam int WBF_LSB     = 0;
  localparam int NBF_LSB     = 16;
  localparam int DSTEP_LSB   = 0;
  localparam int DPER_LSB    = 8;
  localparam int ST_CUT_BIT  = 9;
  localparam int ST_FADE_BIT = 10;
  localparam int ST_PEAK_LSB = 12;

  // ----------------------------------------
  // Gain source selection
  // ----------------------------------------
  typedef enum logic [1:0] {
    MODE_SLOW   = 2'b00,
    MODE_ATTACK = 2'b01,
    MODE_DECAY  = 2'b10,
    MODE_HOLD   = 2'b11
  } rxagc_mode_t;

  // ----------------------------------------
  // Shared arithmetic
  // ----------------------------------------
  function automatic logic [15:0] rxagc_abs(input logic [15:0] v);
    return v[15] ? 16'(~v + 16'h0001) : v;
  endfunction

  // Piecewise-linear log2, six fraction bits, returned as loss below full scale
  function automatic logic [9:0] rxagc_atten(input logic [15:0] mag);
    logic [3:0]  pos;
    logic [15:0] norm;
    logic [9:0]  lg;
    pos = 4'h0;
    for (int b = 0; b < 16; b++) begin
      if (mag[b]) begin
        pos = 4'(b);
      end
    end
    norm = mag << (4'hF - pos);
    lg   = {pos, norm[14:9]};
    if (mag == 16'h0000) begin
      return ATTEN_ZERO;
    end
    // Only an exactly full-scale magnitude reaches the top code
    if (lg >= LOG_FULL) begin
      return 10'h000;
    end
    return LOG_FULL - lg;
  endfunction

  function automatic logic [ACC_W-1:0] rxagc_sat(input logic signed [ACC_W+1:0] v);
    if (v < 0) begin
      return '0;
    end
    if (v[ACC_W+1:ACC_W] != 2'b00) begin
      return '1;
    end
    return v[ACC_W-1:0];
  endfunction

endpackage

// >>> rtl/rxagc_peak.sv
`timescale 1ns/1ps
module rxagc_peak import rxagc_pkg::*; (
  input  logic        mclk,   // Encode clock
  input  logic        rst,    // Async reset
  input  logic        valid,  // Sample strobe
  input  logic [15:0] in_i,   // In-phase sample
  input  logic [15:0] in_q,   // Quadrature sample
  input  logic [7:0]  period, // Samples per peak
  output logic        done,   // Peak ready pulse
  output logic [9:0]  atten   // Peak loss below full scale
);

  logic [15:0] mag;
  logic [15:0] peak_reg;
  logic [15:0] peak_next;
  logic [7:0]  cnt_reg;
  logic [7:0]  per_eff;
  logic        last;

  assign mag       = (rxagc_abs(in_i) > rxagc_abs(in_q)) ? rxagc_abs(in_i) : rxagc_abs(in_q);
  assign peak_next = (mag > peak_reg) ? mag : peak_reg;
  assign per_eff   = (period == 8'h00) ? 8'h01 : period;
  assign last      = cnt_reg >= 8'(per_eff - 8'h01);

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      cnt_reg  <= 8'h00;
      peak_reg <= 16'h0000;
      done     <= 1'b0;
      atten    <= ATTEN_ZERO;
    end else begin
      done <= 1'b0;
      if (valid) begin
        if (last) begin
          cnt_reg  <= 8'h00;
          peak_reg <= 16'h0000;
          done     <= 1'b1;
          atten    <= rxagc_atten(peak_next);
        end else begin
          cnt_reg  <= 8'(cnt_reg + 8'h01);
          peak_reg <= peak_next;
        end
      end
    end
  end

  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);

  peak_hold_a: assert property (valid && !last |=> peak_reg >= $past(mag))
    else $error("peak lost a larger sample");
  peak_done_a: assert property (
    valid && last |=> done && atten == rxagc_atten($past(peak_next)))
    else $error("peak result wrong at period end");

endmodule

// >>> rtl/rxagc_cut_timer.sv
`timescale 1ns/1ps
module rxagc_cut_timer (
  input  logic       mclk,  // Encode clock
  input  logic       rst,   // Async reset
  input  logic       start, // Threshold crossing
  input  logic [4:0] load,  // Cycles to cut
  output logic       busy   // Cut in progress
);

  logic [4:0] cnt_reg;

  // Retrigger restarts the run; start is only the overdrive rising edge, so a sustained overdrive gives a single run
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      cnt_reg <= 5'h00;
      busy    <= 1'b0;
    end else if (start) begin
      cnt_reg <= load;
      busy    <= 1'b1;
    end else if (busy) begin
      cnt_reg <= 5'(cnt_reg - 5'h01);
      busy    <= cnt_reg != 5'h01;
    end
  end

  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);

  cut_load_a: assert property (start |=> busy && cnt_reg == $past(load))
    else $error("cut timer did not load");
  cut_end_a: assert property (busy && cnt_reg == 5'h01 && !start |=> !busy)
    else $error("cut ran past its count");

endmodule

// >>> sim/rxagc_front_model.sv
`timescale 1ns/1ps
module rxagc_front_model (
  input  logic        mclk,      // Encode clock
  input  logic        rst,       // Async reset
  input  logic [11:0] amp,       // Commanded input level
  input  logic        trip,      // Commanded overload
  output logic        adc_valid, // Sample strobe
  output logic [11:0] adc_i,     // Converter I
  output logic [11:0] adc_q,     // Converter Q
  output logic        overdrive  // Comparator output
);
  logic [1:0] phase_reg;
  // ----------------------------------------
  // One conversion every fourth encode edge
  // ----------------------------------------
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      phase_reg <= 2'h0;
      adc_valid <= 1'b0;
    end else begin
      phase_reg <= phase_reg + 2'h1;
      adc_valid <= (phase_reg == 2'h3);
    end
  end
  // Off-strobe data is inverted so stale values never look valid
  assign adc_i = adc_valid ? amp : ~amp;
  assign adc_q = adc_valid ? amp : ~amp;
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      overdrive <= 1'b0;
    end else begin
      overdrive <= trip;
    end
  end
endmodule

// >>> sim/receiver_agc_loops_bench.sv
`timescale 1ns/1ps
module receiver_agc_loops_bench;
  import rxagc_pkg::*;
  logic              mclk;
  logic              rst = 1'b1;
  logic              psel = 1'b0;
  logic              penable = 1'b0;
  logic              pwrite = 1'b0;
  logic [7:0]        paddr = 8'h00;
  logic [31:0]       pwdata = 32'h0;
  logic [31:0]       prdata, rd;
  logic              pready, pslverr, er, adc_valid, overdrive, cut, fade;
  logic              nb_valid = 1'b0;
  logic              trip = 1'b0;
  logic [15:0]       nb_i = 16'h0000;
  logic [15:0]       nb_q = 16'h0000;
  logic [11:0]       amp = 12'h400;
  logic [11:0]       adc_i, adc_q;
  logic [GAIN_W-1:0] gain, g0;
  int                error_cnt = 0;
  int                check_count = 0;
  // Address, expected read data, expected error
  localparam logic [40:0] ROWS [7] = '{{OFF_CTRL, CTRL_RST, 1'b0},
    {OFF_SLOW, SLOW_RST, 1'b0}, {OFF_ATTACK, ATTACK_RST, 1'b0},
    {OFF_FLOOR, FLOOR_RST, 1'b0}, {OFF_DECAY, DECAY_RST, 1'b0}, {8'h18, 32'h0, 1'b1},
    {OFF_STATUS, 10'h000, ATTEN_ZERO, 3'b000, GAIN_INIT, 1'b0}};

  rxagc_top rxagc_top_inst (.mclk(mclk), .rst(rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .adc_valid(adc_valid), .adc_i(adc_i), .adc_q(adc_q),
    .nb_valid(nb_valid), .nb_i(nb_i), .nb_q(nb_q), .overdrive(overdrive),
    .stepped_front_gain(gain), .quick_gain_cut_loop(cut), .fade_recovery_loop(fade));
  rxagc_front_model rxagc_front_model_inst (.mclk(mclk), .rst(rst), .amp(amp), .trip(trip),
    .adc_valid(adc_valid), .adc_i(adc_i), .adc_q(adc_q), .overdrive(overdrive));

  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      error_cnt++;
      $display("unexpected %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task give_verdict;
    $display("checks %0d errors %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // Request held until pready is seen high at a rising edge
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
    @(posedge mclk);
    penable <= 1'b1;
    do begin
      @(posedge mclk);
    end while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    {psel, penable} <= 2'b00;
  endtask
  task nb_peak(input logic [15:0] v);
    repeat (4) begin
      @(posedge mclk);
      {nb_valid, nb_i, nb_q} <= {1'b1, v, v};
      @(posedge mclk);
      {nb_valid, nb_i, nb_q} <= {1'b0, ~v, ~v};
    end
    repeat (4) @(posedge mclk);
    #1;
  endtask
  task cut_run(input logic [4:0] c, input logic [4:0] s);
    int hi;
    logic [9:0] drop;
    hi = 0;
    drop = (10'(c) + 10'h1) * 10'(s);
    apb(1'b1, OFF_ATTACK, {19'h0, c, 3'h0, s});
    g0 = gain;
    trip <= 1'b1;
    repeat (40) begin
      @(posedge mclk);
      #1;
      hi += int'(cut === 1'b1);
    end
    trip <= 1'b0;
    check("cut cycles", 32'(hi), 32'(c) + 32'h1);
    check("cut gain", 32'(gain), (10'(g0) > drop) ? 32'(10'(g0) - drop) : 32'h0);
  endtask
  // ----------------------------------------
  // Sequence
  // ----------------------------------------
  initial begin
    repeat (20) @(posedge mclk);
    rst <= 1'b0;
    @(posedge mclk);
    #1;
    check("reset gain", 32'(gain), 32'(GAIN_INIT));
    check("reset flags", {30'h0, cut, fade}, 32'h0);
    foreach (ROWS[k]) begin
      apb(1'b0, ROWS[k][40:33], 32'h0);
      check("read", rd, ROWS[k][32:1]);
      check("slverr", 32'(er), 32'(ROWS[k][0]));
    end
    apb(1'b1, OFF_SLOW, 32'h1218_0140);
    g0 = gain;
    repeat (300) @(posedge mclk);
    #1;
    check("hold at target", 32'(gain), 32'(g0));
    amp <= 12'h001;
    repeat (300) @(posedge mclk);
    #1;
    check("slow raise", 32'(gain > g0), 32'h1);
    amp <= 12'h400;
    // Slowest factor keeps the slow loop out of the fast-loop figures
    apb(1'b1, OFF_SLOW, 32'h1218_0F40);
    cut_run(5'd16, 5'd16);
    cut_run(5'd1, 5'd1);
    repeat (250) @(posedge mclk);
    nb_peak(16'h0000);
    check("fade strong wb", 32'(fade), 32'h0);
    amp <= 12'h001;
    repeat (250) @(posedge mclk);
    nb_peak(16'h0000);
    check("fade engage", 32'(fade), 32'h1);
    g0 = gain;
    nb_peak(16'h0000);
    check("fade step", 32'(gain), 32'(g0) + 32'h1);
    cut_run(5'd4, 5'd8);
    nb_peak(16'h4000);
    check("fade strong nb", 32'(fade), 32'h0);
    // Disabled block must neither cut nor move the gain
    apb(1'b1, OFF_CTRL, 32'h0);
    @(posedge mclk);
    g0 = gain;
    trip <= 1'b1;
    repeat (10) @(posedge mclk);
    trip <= 1'b0;
    check("disabled cut", {31'h0, cut}, 32'h0);
    check("disabled gain", 32'(gain), 32'(g0));
    give_verdict();
  end
  initial begin
    repeat (20000) @(posedge mclk);
    error_cnt++;
    give_verdict();
  end
endmodule
